// ==== dv/wcc_host.sv ====
// Host model driving the register strobe port
`timescale 1ns/100ps
`default_nettype none
module wcc_host (
  input  wire logic        core_clk,
  output var  logic [7:0]  reg_addr,
  output var  logic [23:0] reg_wdata,
  output var  logic        reg_wr,
  output var  logic        reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 24'h000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse so stale values never pass for fresh
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  // Write followed at once by a read of the same offset, no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [23:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule
`default_nettype wire

// ==== dv/wetting_current_config_regs_test.sv ====
// Self-checking bench for the wetting current configuration registers
`timescale 1ns/100ps
`default_nettype none
module wetting_current_config_regs_test;
  logic        core_clk, nrst, reg_wr, reg_rd, continuous_mode;
  logic [7:0]  reg_addr;
  logic [23:0] reg_wdata, reg_rd_data, input_enable, switch_closed;
  logic [9:0]  current_source_select;
  logic [71:0] wetting_level;
  int          n_mismatch = 0;
  int          comparisons = 0;
  wcc_host host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  wcc_regs dut_u (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .current_source_select(current_source_select),
    .input_enable(input_enable), .continuous_mode(continuous_mode), .switch_closed(switch_closed),
    .wetting_level(wetting_level));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk_reg(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_lvl(input int i, input logic [2:0] exp);
    comparisons++;
    if (wetting_level[3*i+:3] !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, wetting_level[3*i+:3], exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [23:0] exp);
    host_u.rd(a);
    chk_reg(reg_rd_data, exp);
  endtask
  // Level outputs lag the register by one more cycle
  task automatic settle();
    repeat (2) @(negedge core_clk);
  endtask
  function automatic logic [2:0] lvl_of(input logic [2:0] c);
    return (c > 3'h4) ? 3'h5 : c;
  endfunction
  task automatic t_decode();
    logic [23:0] w;
    for (int c = 0; c < 8; c++) begin
      w = {3'(c), 3'(c), 3'(7 - c), 3'(c), 3'(c), 3'(c), 3'(7 - c), 3'(c)};
      host_u.wr(8'h1D, w);
      settle();
      chk_lvl(0, lvl_of(3'(c)));
      chk_lvl(1, lvl_of(3'(c)));
      chk_lvl(2, lvl_of(3'(7 - c)));
      chk_lvl(3, lvl_of(3'(7 - c)));
      for (int i = 4; i < 12; i++) chk_lvl(i, lvl_of(3'((i == 8 || i == 9) ? 7 - c : c)));
      rd_chk(8'h1D, w);
    end
    $display("test decode done");
  endtask
  task automatic t_high();
    logic [2:0] exp [12] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h3, 3'h3, 3'h2, 3'h1};
    host_u.wr_rd(8'h1E, 24'hABCDEF);
    chk_reg(reg_rd_data, 24'h2BCDEF);
    host_u.wr(8'h1E, 24'hFFFFFF);
    rd_chk(8'h1E, 24'h7FFFFF);
    host_u.wr(8'h1E, 24'h053977);
    host_u.wr(8'h1F, 24'hFFFFFF);
    rd_chk(8'h1F, 24'h000000);
    rd_chk(8'h1E, 24'h053977);
    for (int i = 12; i < 24; i++) chk_lvl(i, exp[i - 12]);
    $display("test high register done");
  endtask
  task automatic t_scale();
    host_u.wr(8'h1D, 24'h000024);
    current_source_select = 10'h001;
    input_enable = 24'hFFFFFF;
    switch_closed = 24'h001003;
    continuous_mode = 1'b1;
    host_u.wr(8'h1E, 24'h000004);
    settle();
    chk_lvl(0, 3'h2);
    chk_lvl(1, 3'h2);
    chk_lvl(12, 3'h2);
    chk_lvl(13, 3'h4);
    host_u.wr(8'h1E, 24'h400004);
    settle();
    chk_lvl(0, 3'h4);
    chk_lvl(1, 3'h2);
    chk_lvl(12, 3'h2);
    host_u.wr(8'h1E, 24'h200004);
    settle();
    chk_lvl(0, 3'h2);
    chk_lvl(1, 3'h4);
    chk_lvl(12, 3'h4);
    current_source_select = 10'h000;
    host_u.wr(8'h1D, 24'h000025);
    settle();
    chk_lvl(0, 3'h5);
    chk_lvl(1, 3'h5);
    continuous_mode = 1'b0;
    host_u.wr(8'h1E, 24'h000004);
    settle();
    chk_lvl(12, 3'h4);
    $display("test scaling done");
  endtask
  task automatic t_reset();
    host_u.wr(8'h1D, 24'h123456);
    host_u.rd(8'h1D);
    nrst = 1'b0;
    repeat (2) @(negedge core_clk);
    chk_reg(reg_rd_data, 24'h000000);
    for (int i = 0; i < 24; i++) chk_lvl(i, 3'h0);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    rd_chk(8'h1E, 24'h000000);
    rd_chk(8'h1D, 24'h000000);
    $display("test reset done");
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    current_source_select = 10'h000;
    input_enable = 24'h000000;
    switch_closed = 24'h000000;
    continuous_mode = 1'b0;
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    rd_chk(8'h1E, 24'h000000);
    rd_chk(8'h1D, 24'h000000);
    t_decode();
    t_high();
    t_scale();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== rtl/wcc_level_dec.sv ====
// Per-input wetting level decode with closure down-scaling
`timescale 1ns/100ps
`default_nettype none
module wcc_level_dec (
  wcc_lvl_if.dec p
);
  function automatic wcc_pkg::wcc_lvl_t base_level(input logic [2:0] c);
    if (c > wcc_pkg::CODE_MAX_PLAIN) begin
      return wcc_pkg::WCC_15MA; // [RULE_02]
    end
    return wcc_pkg::wcc_lvl_t'(c); // [RULE_01]
  endfunction

  wcc_pkg::wcc_lvl_t base;

  always_comb begin
    base = base_level(p.code);
    // Only the two high levels scale; lower levels already limit heating
    if (p.scale_ok && (base == wcc_pkg::WCC_10MA || base == wcc_pkg::WCC_15MA)) begin
      p.level = wcc_pkg::WCC_2MA; // [RULE_06] [RULE_07]
    end else begin
      p.level = base;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/wcc_lvl_if.sv ====
// Carrier between the register slice and one input's level decoder
`timescale 1ns/100ps
`default_nettype none
interface wcc_lvl_if;
  logic [2:0]        code;
  logic              scale_ok;
  wcc_pkg::wcc_lvl_t level;
  modport src (output code, output scale_ok, input level);
  modport dec (input code, input scale_ok, output level);
endinterface
`default_nettype wire

// ==== rtl/wcc_pkg.sv ====
// Constants and types for the wetting current configuration registers
// Contract
// RULE_01: Each 3-bit level code decodes 0 to off, 1 to 1 mA, 2 to 2 mA, 3 to 5 mA and 4 to 10 mA.
// RULE_02: Codes 5, 6 and 7 all select the same 15 mA level.
// RULE_03: Low register bits 2-0 drive inputs 0 and 1 together, bits 5-3 drive inputs 2 and 3 together.
// RULE_04: The high register sits at offset 0x1E and reads all zeros after reset.
// RULE_05: High register bits 20-18 drive input 23, 17-15 input 22, 14-12 inputs 20/21, 11-0 pairs 18/19 to 12/13.
// RULE_06: With bit 22 clear, closed enabled sink inputs at 10 or 15 mA drop to 2 mA in continuous mode.
// RULE_07: With bit 21 clear, closed enabled source inputs at 10 or 15 mA drop to 2 mA in continuous mode.
// RULE_08: Reserved top bits of the high register are read-only zero; all other fields read and write.
// RULE_09: A select bit of zero puts an input in the source group, one in the sink group.
// RULE_10: Writes to reserved bits are dropped and those bits stay zero.
`default_nettype none
package wcc_pkg;
  localparam logic [7:0]  ADDR_LOW       = 8'h1D;
  localparam logic [7:0]  ADDR_HIGH      = 8'h1E;
  localparam logic [23:0] RESET_LOW      = 24'h000000;
  localparam logic [23:0] RESET_HIGH     = 24'h000000;
  localparam logic [23:0] HIGH_WR_MASK   = 24'h7FFFFF;
  localparam int          SINK_OFF_BIT   = 22;
  localparam int          SOURCE_OFF_BIT = 21;
  localparam int          NUM_INPUTS     = 24;
  localparam int          NUM_SELECT     = 10;
  localparam int          CODE_W         = 3;
  localparam logic [2:0]  CODE_MAX_PLAIN = 3'h4;

  // Field LSB in the {high, low} 48-bit concatenation, per input
  localparam int FIELD_LSB [NUM_INPUTS] = '{
    0, 0, 3, 3, 6, 9, 12, 12, 15, 15, 18, 21,
    24, 24, 27, 27, 30, 30, 33, 33, 36, 36, 39, 42};

  typedef enum logic [2:0] {
    WCC_OFF  = 3'h0,
    WCC_1MA  = 3'h1,
    WCC_2MA  = 3'h2,
    WCC_5MA  = 3'h3,
    WCC_10MA = 3'h4,
    WCC_15MA = 3'h5
  } wcc_lvl_t;

  typedef struct packed {
    logic [23:0] low;
    logic [23:0] high;
    logic [23:0] rd;
    logic [71:0] lvl;
  } wcc_state_t;
endpackage
`default_nettype wire

// ==== rtl/wcc_regs.sv ====
// Wetting current configuration registers and per-input level outputs
`timescale 1ns/100ps
`default_nettype none
module wcc_regs (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [23:0] reg_rd_data,
  input  wire logic [9:0]  current_source_select,
  input  wire logic [23:0] input_enable,
  input  wire logic        continuous_mode,
  input  wire logic [23:0] switch_closed,
  output var  logic [71:0] wetting_level
);
  logic [1:0]          rst_sync_q;
  logic                rst_n_s;
  wcc_pkg::wcc_state_t s_q;
  wcc_pkg::wcc_state_t s_d;
  logic [47:0]         cat;
  logic [2:0]          codes_w [wcc_pkg::NUM_INPUTS];
  logic [2:0]          lvl_w   [wcc_pkg::NUM_INPUTS];

  // Asynchronous assert, synchronous release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_q[1];

  function automatic logic is_sink(input int i, input logic [9:0] sel);
    // Inputs above the selectable set are fixed to the source group
    if (i < wcc_pkg::NUM_SELECT) begin
      return sel[i]; // [RULE_09]
    end
    return 1'b0;
  endfunction

  assign cat = {s_q.high, s_q.low};

  wcc_lvl_if lvl_if [wcc_pkg::NUM_INPUTS] ();

  genvar gi;
  generate
    for (gi = 0; gi < wcc_pkg::NUM_INPUTS; gi++) begin : g_in
      assign codes_w[gi] = cat[wcc_pkg::FIELD_LSB[gi] +: wcc_pkg::CODE_W]; // [RULE_03] [RULE_05]
      assign lvl_if[gi].code = codes_w[gi];
      assign lvl_if[gi].scale_ok = continuous_mode && input_enable[gi] && switch_closed[gi] &&
        (is_sink(gi, current_source_select) ? !s_q.high[wcc_pkg::SINK_OFF_BIT]      // [RULE_06]
                                            : !s_q.high[wcc_pkg::SOURCE_OFF_BIT]); // [RULE_07]
      assign lvl_w[gi] = lvl_if[gi].level;
      wcc_level_dec u_dec (
        .p (lvl_if[gi])
      );
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    if (reg_wr && reg_addr == wcc_pkg::ADDR_LOW) begin
      s_d.low = reg_wdata;
    end
    if (reg_wr && reg_addr == wcc_pkg::ADDR_HIGH) begin
      s_d.high = reg_wdata & wcc_pkg::HIGH_WR_MASK; // [RULE_04] [RULE_08] [RULE_10]
    end
    if (reg_rd) begin
      case (reg_addr)
        wcc_pkg::ADDR_LOW:  s_d.rd = s_q.low;
        wcc_pkg::ADDR_HIGH: s_d.rd = s_q.high & wcc_pkg::HIGH_WR_MASK; // [RULE_08]
        // Unmapped offsets read zero so a probe never sees stale data
        default:            s_d.rd = 24'h000000;
      endcase
    end
    for (int i = 0; i < wcc_pkg::NUM_INPUTS; i++) begin
      s_d.lvl[i*3 +: 3] = lvl_w[i];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_q <= '{low: wcc_pkg::RESET_LOW, high: wcc_pkg::RESET_HIGH, rd: 24'h000000, lvl: 72'h0}; // [RULE_04]
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rd_data   = s_q.rd;
  assign wetting_level = s_q.lvl;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_s);

  sequence s_high_write;
    reg_wr && reg_addr == wcc_pkg::ADDR_HIGH;
  endsequence

  sequence s_sink_closed_10ma;
    continuous_mode && input_enable[0] && switch_closed[0] && current_source_select[0] &&
      !s_q.high[wcc_pkg::SINK_OFF_BIT] && codes_w[0] == 3'h4;
  endsequence

  a_code_zero_off: assert property (codes_w[4] == 3'h0 |=> wetting_level[14:12] == 3'h0) // [RULE_01]
    else $error("Code zero did not give off level");
  a_code_one_1ma: assert property (codes_w[5] == 3'h1 |=> wetting_level[17:15] == 3'h1) // [RULE_01]
    else $error("Code one did not give 1 mA");
  a_top_codes_same: assert property (codes_w[11] > 3'h4 && !lvl_if[11].scale_ok |=> wetting_level[35:33] == 3'h5) // [RULE_02]
    else $error("High code did not give 15 mA");
  a_pair_shared: assert property (codes_w[0] == s_q.low[2:0] && codes_w[1] == s_q.low[2:0] &&
    codes_w[3] == s_q.low[5:3] && codes_w[23] == s_q.high[20:18] && codes_w[21] == s_q.high[14:12]) // [RULE_03]
    else $error("Shared field mapping wrong");
  a_high_write_masked: assert property (s_high_write |=> s_q.high == ($past(reg_wdata) & 24'h7FFFFF)) // [RULE_10]
    else $error("High register write not masked");
  a_high_reads_back: assert property (s_high_write ##1 (reg_rd && reg_addr == 8'h1E && !reg_wr)
    |=> reg_rd_data == ($past(reg_wdata, 2) & 24'h7FFFFF) && reg_rd_data[23] == 1'b0) // [RULE_04] [RULE_08]
    else $error("High register readback wrong");
  a_sink_scaled: assert property (s_sink_closed_10ma |=> wetting_level[2:0] == 3'h2) // [RULE_06]
    else $error("Sink input not scaled to 2 mA");
  a_source_kept: assert property (continuous_mode && input_enable[12] && switch_closed[12] &&
    s_q.high[wcc_pkg::SOURCE_OFF_BIT] && codes_w[12] == 3'h4 |=> wetting_level[38:36] == 3'h4) // [RULE_07]
    else $error("Source scaling not suppressed");
  a_group_select: assert property (continuous_mode && input_enable[0] && switch_closed[0] &&
    !current_source_select[0] && s_q.high[21] && !s_q.high[22] && codes_w[0] == 3'h5
    |=> wetting_level[2:0] == 3'h5) // [RULE_09]
    else $error("Group select used wrong scaling bit");

  sequence s_low_write;
    reg_wr && reg_addr == wcc_pkg::ADDR_LOW;
  endsequence

  sequence s_low_read;
    reg_rd && reg_addr == wcc_pkg::ADDR_LOW;
  endsequence

  sequence s_high_read;
    reg_rd && reg_addr == wcc_pkg::ADDR_HIGH;
  endsequence

  sequence s_unmapped_write;
    reg_wr && reg_addr != wcc_pkg::ADDR_LOW && reg_addr != wcc_pkg::ADDR_HIGH;
  endsequence

  sequence s_unmapped_read;
    reg_rd && reg_addr != wcc_pkg::ADDR_LOW && reg_addr != wcc_pkg::ADDR_HIGH;
  endsequence

  a_code_two_2ma: assert property (codes_w[6] == 3'h2 // [RULE_01]
    |=> wetting_level[20:18] == 3'h2)
    else $error("Code two did not give 2 mA");

  a_code_three_5ma: assert property (codes_w[8] == 3'h3 // [RULE_01]
    |=> wetting_level[26:24] == 3'h3)
    else $error("Code three did not give 5 mA");

  a_code_four_10ma: assert property (codes_w[10] == 3'h4 && !lvl_if[10].scale_ok // [RULE_01]
    |=> wetting_level[32:30] == 3'h4)
    else $error("Code four did not give 10 mA");

  a_code_six_same: assert property (codes_w[7] == 3'h6 && !lvl_if[7].scale_ok // [RULE_02]
    |=> wetting_level[23:21] == 3'h5)
    else $error("Code six did not give 15 mA");

  a_code_seven_same: assert property (codes_w[9] == 3'h7 && !lvl_if[9].scale_ok // [RULE_02]
    |=> wetting_level[29:27] == 3'h5)
    else $error("Code seven did not give 15 mA");

  a_pair_levels_equal: assert property (lvl_if[2].scale_ok == lvl_if[3].scale_ok // [RULE_03]
    |=> wetting_level[8:6] == wetting_level[11:9])
    else $error("Low pair levels differ");

  a_pair_high_equal: assert property (lvl_if[14].scale_ok == lvl_if[15].scale_ok // [RULE_05]
    |=> wetting_level[44:42] == wetting_level[47:45])
    else $error("High pair levels differ");

  a_input_23_field: assert property (s_q.high[20:18] == 3'h1 // [RULE_05]
    |=> wetting_level[71:69] == 3'h1)
    else $error("Input 23 field mapping wrong");

  a_input_22_field: assert property (s_q.high[17:15] == 3'h2 // [RULE_05]
    |=> wetting_level[68:66] == 3'h2)
    else $error("Input 22 field mapping wrong");

  a_pair_20_21: assert property (s_q.high[14:12] == 3'h3 // [RULE_05]
    |=> wetting_level[62:60] == 3'h3 && wetting_level[65:63] == 3'h3)
    else $error("Inputs 20 and 21 field mapping wrong");

  a_low_write_full: assert property (s_low_write // [RULE_03]
    |=> s_q.low == $past(reg_wdata))
    else $error("Low register write lost bits");

  a_low_read_data: assert property (s_low_read // [RULE_03]
    |=> reg_rd_data == $past(s_q.low))
    else $error("Low register read data wrong");

  a_high_read_data: assert property (s_high_read // [RULE_08]
    |=> reg_rd_data == $past(s_q.high) && reg_rd_data[23] == 1'b0)
    else $error("High register read data wrong");

  a_unmapped_write_kept: assert property (s_unmapped_write // [RULE_04]
    |=> $stable(s_q.low) && $stable(s_q.high))
    else $error("Unmapped write changed a register");

  a_unmapped_reads_zero: assert property (s_unmapped_read // [RULE_04]
    |=> reg_rd_data == 24'h000000)
    else $error("Unmapped read not zero");

  a_reserved_stays_zero: assert property (s_q.high[23] == 1'b0) // [RULE_10]
    else $error("Reserved high bit set");

  // Inputs 0 and 12 are watched so that both group bits are seen acting
  a_sink_off_kept: assert property (continuous_mode && input_enable[0] && switch_closed[0] && // [RULE_06]
    current_source_select[0] && s_q.high[wcc_pkg::SINK_OFF_BIT] && codes_w[0] == 3'h4 |=> wetting_level[2:0] == 3'h4)
    else $error("Sink scaling not suppressed");

  a_source_scaled: assert property (continuous_mode && input_enable[12] && switch_closed[12] && // [RULE_07]
    !s_q.high[wcc_pkg::SOURCE_OFF_BIT] && codes_w[12] == 3'h4 |=> wetting_level[38:36] == 3'h2)
    else $error("Source input not scaled to 2 mA");

  a_open_not_scaled: assert property (!switch_closed[0] && codes_w[0] == 3'h4 // [RULE_06]
    |=> wetting_level[2:0] == 3'h4)
    else $error("Open input was scaled");

  a_disabled_not_scaled: assert property (!input_enable[2] && codes_w[2] == 3'h4 // [RULE_06]
    |=> wetting_level[8:6] == 3'h4)
    else $error("Disabled input was scaled");

  a_polling_not_scaled: assert property (!continuous_mode && codes_w[1] == 3'h5 // [RULE_07]
    |=> wetting_level[5:3] == 3'h5)
    else $error("Input scaled outside continuous mode");
endmodule
`default_nettype wire
